// *** hdl/gpio_port.v ***
// general purpose i/o port block with classic wishbone register slave
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"

// Functional notes
// - fifteen bidirectional pins: port_one 0-7, port_three 3,4,5,7, port_four 5,6,7
// - port_four bits 6 and 7 are gpio only while the crystal oscillator is unused
// - port_four bit 2 is input only, usable only while the adc is unused
// - one direction bit per pin; 0 is input, 1 is output
// - in input mode a data read returns the pin level
// - in output mode a data read returns the port latch
// - data writes always update the latch, whatever the direction
// - in output mode the pin is driven with the latch value
// - selectable pull-ups in input mode, grouped per port as documented
// - input threshold of 35, 50 or 70 percent per port group
// - a peripheral output drives its pin whatever the direction bit says
// - some direction bits are unimplemented, others reserved
// - unimplemented and reserved direction bits read 0; software writes 0
module gpio_port #(
    parameter ADR_W = 12
) (
    input wire sys_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire osc_in_use,
    input wire adc_in_use,
    input wire [7:0] periph_one_oe,
    input wire [7:0] periph_one_out,
    input wire [7:0] periph_three_oe,
    input wire [7:0] periph_three_out,
    input wire [7:0] periph_four_oe,
    input wire [7:0] periph_four_out,
    input wire [7:0] port_one_in,
    output reg [7:0] port_one_out,
    output reg [7:0] port_one_oe,
    output reg [7:0] port_one_pullup,
    input wire [7:0] port_three_in,
    output reg [7:0] port_three_out,
    output reg [7:0] port_three_oe,
    output reg [7:0] port_three_pullup,
    input wire [7:0] port_four_in,
    output reg [7:0] port_four_out,
    output reg [7:0] port_four_oe,
    output reg [7:0] port_four_pullup,
    input wire analog_shared_input_pin,
    output reg [1:0] port_one_threshold,
    output reg [1:0] port_three_threshold,
    output reg [1:0] port_four_threshold,
    output reg [7:0] port_one_level,
    output reg [7:0] port_three_level,
    output reg [7:0] port_four_level
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------

    // per bit: latch in output mode, pin level in input mode
    function [7:0] port_read;
        input [7:0] dir;
        input [7:0] lat;
        input [7:0] lvl;
        input [7:0] impl;
        begin
            port_read = ((dir & lat) | (~dir & lvl)) & impl;
        end
    endfunction

    // peripheral output wins over the port latch and direction
    function [7:0] pin_value;
        input [7:0] p_oe;
        input [7:0] p_out;
        input [7:0] lat;
        begin
            pin_value = (p_oe & p_out) | (~p_oe & lat);
        end
    endfunction

    function [7:0] pin_enable;
        input [7:0] p_oe;
        input [7:0] dir;
        input [7:0] impl;
        begin
            pin_enable = (p_oe | dir) & impl;
        end
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    reg [7:0] dir_one;
    reg [7:0] dir_three;
    reg [7:0] dir_four;
    reg [7:0] latch_one;
    reg [7:0] latch_three;
    reg [7:0] latch_four;
    reg [1:0] pullup_select_reg_a;
    reg [2:0] pullup_select_reg_b;
    reg [3:0] threshold_select_reg_a;
    reg [1:0] threshold_select_reg_b;

    wire [7:0] sync_one;
    wire [7:0] sync_three;
    wire [7:0] sync_four;
    wire sync_analog;

    reg [31:0] next_rdata;
    reg [7:0] impl_four;
    reg [7:0] level_four;
    reg [7:0] next_pullup_one;
    reg [7:0] next_pullup_three;
    reg [7:0] next_pullup_four;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    gpio_sync2 #(
        .W(25)
    ) u_sync_pins (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({analog_shared_input_pin, port_four_in, port_three_in, port_one_in}),
        .sync_out({sync_analog, sync_four, sync_three, sync_one})
    );

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire [7:0] idx = wb_adr_i[9:2];
    wire hi_zero = ((wb_adr_i >> 10) == {ADR_W{1'b0}});
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // only byte lane 0 carries register data; other lanes are ignored
    wire wr = req & wb_we_i & wb_sel_i[0] & hi_zero;
    wire [7:0] wdat = wb_dat_i[7:0];

    // ------------------------------------------------------------------------
    // port four availability and levels
    // ------------------------------------------------------------------------
    always @* begin
        impl_four = `GPIO_IMPL4;
        if (osc_in_use) begin
            impl_four = `GPIO_IMPL4 & ~`GPIO_OSC_BITS;
        end
        level_four = sync_four & impl_four;
        // the analog pin has no driver; it only shows while the adc is idle
        level_four[`GPIO_ANALOG_BIT] = sync_analog & ~adc_in_use;
    end

    // ------------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hi_zero) begin
            case (idx)
                `GPIO_IDX_DAT1: begin
                    next_rdata[7:0] = port_read(dir_one, latch_one, sync_one, `GPIO_IMPL1);
                end
                `GPIO_IDX_DIR1: begin
                    next_rdata[7:0] = dir_one;
                end
                `GPIO_IDX_DAT3: begin
                    next_rdata[7:0] = port_read(dir_three, latch_three, sync_three, `GPIO_IMPL3);
                end
                `GPIO_IDX_DIR3: begin
                    next_rdata[7:0] = dir_three;
                end
                `GPIO_IDX_DAT4: begin
                    next_rdata[7:0] = port_read(dir_four, latch_four, level_four, impl_four);
                    next_rdata[`GPIO_ANALOG_BIT] = level_four[`GPIO_ANALOG_BIT];
                end
                `GPIO_IDX_DIR4: begin
                    next_rdata[7:0] = dir_four;
                end
                `GPIO_IDX_PUR_A: begin
                    next_rdata[1:0] = pullup_select_reg_a;
                end
                `GPIO_IDX_PUR_B: begin
                    next_rdata[2:0] = pullup_select_reg_b;
                end
                `GPIO_IDX_THR_A: begin
                    next_rdata[3:0] = threshold_select_reg_a;
                end
                `GPIO_IDX_THR_B: begin
                    next_rdata[1:0] = threshold_select_reg_b;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // wishbone answer: ack one cycle after the request, unmapped reads give 0
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dir_one <= `GPIO_DIR_RST;
            dir_three <= `GPIO_DIR_RST;
            dir_four <= `GPIO_DIR_RST;
            latch_one <= `GPIO_LAT_RST;
            latch_three <= `GPIO_LAT_RST;
            latch_four <= `GPIO_LAT_RST;
            pullup_select_reg_a <= `GPIO_PUR_A_RST;
            pullup_select_reg_b <= `GPIO_PUR_B_RST;
            threshold_select_reg_a <= `GPIO_THR_A_RST;
            threshold_select_reg_b <= `GPIO_THR_B_RST;
        end else if (wr) begin
            case (idx)
                `GPIO_IDX_DAT1: begin
                    latch_one <= wdat & `GPIO_IMPL1;
                end
                `GPIO_IDX_DIR1: begin
                    dir_one <= wdat & `GPIO_IMPL1;
                end
                `GPIO_IDX_DAT3: begin
                    latch_three <= wdat & `GPIO_IMPL3;
                end
                `GPIO_IDX_DIR3: begin
                    // unimplemented and reserved bits never store a one
                    dir_three <= wdat & `GPIO_IMPL3;
                end
                `GPIO_IDX_DAT4: begin
                    latch_four <= wdat & `GPIO_IMPL4;
                end
                `GPIO_IDX_DIR4: begin
                    dir_four <= wdat & `GPIO_IMPL4;
                end
                `GPIO_IDX_PUR_A: begin
                    pullup_select_reg_a <= wdat[1:0];
                end
                `GPIO_IDX_PUR_B: begin
                    pullup_select_reg_b <= wdat[2:0];
                end
                `GPIO_IDX_THR_A: begin
                    threshold_select_reg_a <= wdat[3:0];
                end
                `GPIO_IDX_THR_B: begin
                    threshold_select_reg_b <= wdat[1:0];
                end
                default: begin
                    dir_one <= dir_one;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // pull-up selection: only pins that are inputs and not peripheral outputs
    // ------------------------------------------------------------------------
    always @* begin
        next_pullup_one = 8'h00;
        next_pullup_three = 8'h00;
        next_pullup_four = 8'h00;
        if (pullup_select_reg_a[`GPIO_PUR_A_LO1]) begin
            next_pullup_one[3:0] = 4'hf;
        end
        if (pullup_select_reg_a[`GPIO_PUR_A_HI1]) begin
            next_pullup_one[7:4] = 4'hf;
        end
        if (pullup_select_reg_b[`GPIO_PUR_B_BIT3]) begin
            next_pullup_three[3] = 1'b1;
        end
        if (pullup_select_reg_b[`GPIO_PUR_B_GRP3]) begin
            next_pullup_three = next_pullup_three | `GPIO_GRP3_BITS;
        end
        if (pullup_select_reg_b[`GPIO_PUR_B_GRP4]) begin
            next_pullup_four = `GPIO_IMPL4;
        end
        // a driven pin never carries a pull-up
        next_pullup_one = next_pullup_one & ~pin_enable(periph_one_oe, dir_one,
                                                        `GPIO_IMPL1);
        next_pullup_three = next_pullup_three & ~pin_enable(periph_three_oe, dir_three,
                                                            `GPIO_IMPL3);
        next_pullup_four = next_pullup_four & impl_four &
                           ~pin_enable(periph_four_oe, dir_four, impl_four);
    end

    // ------------------------------------------------------------------------
    // pin drive, pull-ups, thresholds and levels, all from flip-flops
    // ------------------------------------------------------------------------
    // the extra register stage costs one cycle from write to pin but keeps
    // every output glitch free
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            port_one_out <= 8'h00;
            port_one_oe <= 8'h00;
            port_one_pullup <= 8'h00;
            port_three_out <= 8'h00;
            port_three_oe <= 8'h00;
            port_three_pullup <= 8'h00;
            port_four_out <= 8'h00;
            port_four_oe <= 8'h00;
            port_four_pullup <= 8'h00;
            port_one_threshold <= 2'h0;
            port_three_threshold <= 2'h0;
            port_four_threshold <= 2'h0;
            port_one_level <= 8'h00;
            port_three_level <= 8'h00;
            port_four_level <= 8'h00;
        end else begin
            port_one_out <= pin_value(periph_one_oe, periph_one_out, latch_one)
                            & `GPIO_IMPL1;
            port_one_oe <= pin_enable(periph_one_oe, dir_one, `GPIO_IMPL1);
            port_one_pullup <= next_pullup_one;
            port_three_out <= pin_value(periph_three_oe, periph_three_out, latch_three)
                              & `GPIO_IMPL3;
            port_three_oe <= pin_enable(periph_three_oe, dir_three,
                                        `GPIO_IMPL3);
            port_three_pullup <= next_pullup_three;
            port_four_out <= pin_value(periph_four_oe, periph_four_out, latch_four)
                             & impl_four;
            // the analog pin bit is outside impl_four, so it is never driven
            port_four_oe <= pin_enable(periph_four_oe, dir_four, impl_four);
            port_four_pullup <= next_pullup_four;
            port_one_threshold <= threshold_select_reg_a[`GPIO_THR_A_LSB1 +: 2];
            port_three_threshold <= threshold_select_reg_a[`GPIO_THR_A_LSB3 +: 2];
            port_four_threshold <= threshold_select_reg_b[`GPIO_THR_B_LSB4 +: 2];
            // peripherals that take a pin as input see the synchronised level
            port_one_level <= sync_one;
            port_three_level <= sync_three & `GPIO_IMPL3;
            port_four_level <= level_four;
        end
    end

endmodule // gpio_port

`default_nettype wire

// *** hdl/gpio_regs.vh ***
// register indices, field positions, masks and reset values of the gpio port block
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define GPIO_IDX_DAT1 8'he1
`define GPIO_IDX_DIR1 8'he3
`define GPIO_IDX_DAT3 8'he5
`define GPIO_IDX_DIR3 8'he7
`define GPIO_IDX_DAT4 8'he8
`define GPIO_IDX_DIR4 8'hea
`define GPIO_IDX_PUR_A 8'hf0
`define GPIO_IDX_PUR_B 8'hf1
`define GPIO_IDX_THR_A 8'hf2
`define GPIO_IDX_THR_B 8'hf3

// ----------------------------------------------------------------------------
// implemented bits of each port
// ----------------------------------------------------------------------------
`define GPIO_IMPL1 8'hff
`define GPIO_IMPL3 8'hb8
`define GPIO_IMPL4 8'he0
`define GPIO_OSC_BITS 8'hc0
`define GPIO_ANALOG_BIT 2

// ----------------------------------------------------------------------------
// pull-up select fields
// ----------------------------------------------------------------------------
`define GPIO_PUR_A_LO1 0
`define GPIO_PUR_A_HI1 1
`define GPIO_PUR_B_BIT3 0
`define GPIO_PUR_B_GRP3 1
`define GPIO_PUR_B_GRP4 2
`define GPIO_GRP3_BITS 8'hb0

// ----------------------------------------------------------------------------
// threshold select fields: 00 = 0.35, 01 = 0.50, 10 = 0.70 of supply
// ----------------------------------------------------------------------------
`define GPIO_THR_A_LSB1 0
`define GPIO_THR_A_LSB3 2
`define GPIO_THR_B_LSB4 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define GPIO_DIR_RST 8'h00
`define GPIO_LAT_RST 8'h00
`define GPIO_PUR_A_RST 2'h0
`define GPIO_PUR_B_RST 3'h0
`define GPIO_THR_A_RST 4'h0
`define GPIO_THR_B_RST 2'h0

`endif

// *** hdl/gpio_sync2.v ***
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none

module gpio_sync2 #(
    parameter W = 8
) (
    input wire sys_clk,
    input wire reset,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

    // first stage is read only by the second stage
    reg [W-1:0] meta;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // gpio_sync2

`default_nettype wire

// *** tb/gpio_port_props.sv ***
// assertion checker for the gpio port block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module gpio_port_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic osc_in_use,
    input wire logic adc_in_use,
    input wire logic [7:0] periph_one_oe,
    input wire logic [7:0] periph_one_out,
    input wire logic [7:0] port_one_out,
    input wire logic [7:0] port_one_oe,
    input wire logic [7:0] port_one_pullup,
    input wire logic [7:0] port_three_oe,
    input wire logic [7:0] port_four_oe,
    input wire logic [7:0] port_four_pullup,
    input wire logic [7:0] port_four_level
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_latency_a: assert property (req_s |=> ack_s) else $error("ack late or too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    three_oe_mask_a: assert property ((port_three_oe & 8'h47) == 8'h00)
        else $error("port three drives a missing pin");
    four_oe_mask_a: assert property ((port_four_oe & 8'h1f) == 8'h00)
        else $error("port four drives a missing pin");
    osc_gate_a: assert property ($past(osc_in_use) |-> port_four_oe[7:6] == 2'b00 &&
        port_four_pullup[7:6] == 2'b00) else $error("oscillator pins still used");
    periph_drive_a: assert property (periph_one_oe != 8'h00 |=>
        (port_one_oe & $past(periph_one_oe)) == $past(periph_one_oe) &&
        (port_one_out & $past(periph_one_oe)) == ($past(periph_one_out) & $past(periph_one_oe)))
        else $error("peripheral output not on pin");
    pullup_off_a: assert property ((port_one_pullup & port_one_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    analog_gate_a: assert property ($past(adc_in_use) |-> !port_four_level[2])
        else $error("analog pin level seen while converter owns it");
    reset_state_a: assert property ($fell(reset) |-> port_one_oe == 8'h00 &&
        port_three_oe == 8'h00 && port_four_oe == 8'h00 && !wb_ack_o)
        else $error("outputs not idle after reset");
endmodule // gpio_port_props
bind gpio_port gpio_port_props gpio_port_props_inst (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .osc_in_use, .adc_in_use, .periph_one_oe, .periph_one_out, .port_one_out,
    .port_one_oe, .port_one_pullup, .port_three_oe, .port_four_oe, .port_four_pullup,
    .port_four_level);
`default_nettype wire

// *** tb/gpio_pin_model.sv ***
// behavioural model of the external devices on one eight-bit port
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model (
    input wire logic sys_clk,
    input wire logic [7:0] drv_out,
    input wire logic [7:0] drv_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_val,
    input wire logic ext_en,
    output logic [7:0] pin
);
    logic [7:0] last = 8'h00;
    always @(posedge sys_clk) begin
        last <= pin;
    end
    // a floating line with no pull-up must not keep its level for free
    always @* begin
        for (int k = 0; k < 8; k++) begin
            if (drv_oe[k]) pin[k] = drv_out[k];
            else if (ext_en) pin[k] = ext_val[k];
            else if (pull_en[k]) pin[k] = 1'b1;
            else pin[k] = ~last[k];
        end
    end
endmodule // gpio_pin_model
`default_nettype wire

// *** tb/tb_general_purpose_io_port.sv ***
// self-checking testbench for the gpio port block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"
module tb_general_purpose_io_port;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    logic osc_in_use = 1'b0;
    logic adc_in_use = 1'b0;
    logic analog_pin = 1'b0;
    logic ext_en = 1'b1;
    logic [7:0] poe [3] = '{default: 8'h00};
    logic [7:0] pout [3] = '{default: 8'h00};
    logic [7:0] ext [3] = '{default: 8'h00};
    logic [7:0] m_dir [3] = '{default: 8'h00};
    logic [7:0] m_lat [3] = '{default: 8'h00};
    logic [7:0] impl [3] = '{`GPIO_IMPL1, `GPIO_IMPL3, `GPIO_IMPL4};
    logic [7:0] didx [3] = '{`GPIO_IDX_DAT1, `GPIO_IDX_DAT3, `GPIO_IDX_DAT4};
    logic [7:0] ridx [3] = '{`GPIO_IDX_DIR1, `GPIO_IDX_DIR3, `GPIO_IDX_DIR4};
    wire [7:0] out_w [3];
    wire [7:0] oe_w [3];
    wire [7:0] pu_w [3];
    wire [7:0] pin_w [3];
    wire [7:0] lvl_w [3];
    wire [1:0] thr_w [3];
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'h6947b076;
    logic [31:0] q;
    always #12.5 sys_clk = ~sys_clk;
    gpio_port gpio_port_inst (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_in_use(osc_in_use),
        .adc_in_use(adc_in_use), .periph_one_oe(poe[0]), .periph_one_out(pout[0]),
        .periph_three_oe(poe[1]), .periph_three_out(pout[1]), .periph_four_oe(poe[2]),
        .periph_four_out(pout[2]), .port_one_in(pin_w[0]), .port_one_out(out_w[0]),
        .port_one_oe(oe_w[0]), .port_one_pullup(pu_w[0]), .port_three_in(pin_w[1]),
        .port_three_out(out_w[1]), .port_three_oe(oe_w[1]), .port_three_pullup(pu_w[1]),
        .port_four_in(pin_w[2]), .port_four_out(out_w[2]), .port_four_oe(oe_w[2]),
        .port_four_pullup(pu_w[2]), .analog_shared_input_pin(analog_pin),
        .port_one_threshold(thr_w[0]), .port_three_threshold(thr_w[1]),
        .port_four_threshold(thr_w[2]), .port_one_level(lvl_w[0]),
        .port_three_level(lvl_w[1]), .port_four_level(lvl_w[2]));
    for (genvar g = 0; g < 3; g++) begin : pins
        gpio_pin_model gpio_pin_model_inst (.sys_clk(sys_clk), .drv_out(out_w[g]),
            .drv_oe(oe_w[g]), .pull_en(pu_w[g]), .ext_val(ext[g]), .ext_en(ext_en),
            .pin(pin_w[g]));
    end
    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // ack and read data are taken at the rising edge where ack is seen high
    task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_dat_i <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) error_cnt++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        chk(q, exp);
    endtask
    function automatic logic [31:0] exp_rd(input int p);
        return {24'h0, ((m_dir[p] & m_lat[p]) | (~m_dir[p] & ext[p])) & impl[p]};
    endfunction
    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        for (int p = 0; p < 3; p++) rd_chk(ridx[p], 32'h0);
        for (int i = 'hf0; i <= 'hf3; i++) rd_chk(8'(i), 32'h0);
        for (int p = 0; p < 3; p++) begin
            wb(1'b1, ridx[p], 32'hff);
            rd_chk(ridx[p], {24'h0, impl[p]});
        end
        repeat (20) begin
            for (int p = 0; p < 3; p++) begin
                ext[p] <= 8'($random(seed));
                m_lat[p] = 8'($random(seed));
                m_dir[p] = 8'($random(seed)) & impl[p];
                wb(1'b1, didx[p], {24'h0, m_lat[p]});
                wb(1'b1, ridx[p], {24'h0, m_dir[p]});
            end
            repeat (4) @(posedge sys_clk);
            for (int p = 0; p < 3; p++) begin
                rd_chk(didx[p], exp_rd(p));
                chk(oe_w[p], m_dir[p]);
                chk(out_w[p] & oe_w[p], m_lat[p] & m_dir[p]);
                chk(lvl_w[p], exp_rd(p));
            end
        end
        for (int p = 0; p < 3; p++) begin
            m_dir[p] = 8'h00;
            wb(1'b1, ridx[p], 32'h0);
        end
        ext_en <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, `GPIO_IDX_PUR_A, 32'(i & 3));
            wb(1'b1, `GPIO_IDX_PUR_B, 32'(i));
            @(posedge sys_clk);
            chk(pu_w[0], {{4{i[1]}}, {4{i[0]}}});
            chk(pu_w[1], (i[0] ? 8'h08 : 8'h00) | (i[1] ? 8'hb0 : 8'h00));
            chk(pu_w[2], i[2] ? 8'he0 : 8'h00);
        end
        repeat (4) @(posedge sys_clk);
        rd_chk(`GPIO_IDX_DAT1, 32'hff);
        ext_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, `GPIO_IDX_THR_A, 32'((i << 2) | i));
            wb(1'b1, `GPIO_IDX_THR_B, 32'(i));
            @(posedge sys_clk);
            for (int p = 0; p < 3; p++) chk(thr_w[p], 32'(i));
        end
        for (int p = 0; p < 3; p++) begin
            poe[p] <= impl[p];
            pout[p] <= 8'($random(seed));
            repeat (2) @(posedge sys_clk);
            chk(oe_w[p], impl[p]);
            chk(out_w[p], pout[p] & impl[p]);
            poe[p] <= 8'h00;
        end
        ext[0] <= 8'h3c;
        repeat (5) @(posedge sys_clk);
        chk(lvl_w[0], 8'h3c);
        ext[0] <= 8'hc3;
        @(posedge sys_clk);
        @(posedge sys_clk);
        chk(lvl_w[0], 8'h3c);
        repeat (4) @(posedge sys_clk);
        chk(lvl_w[0], 8'hc3);
        wb(1'b1, `GPIO_IDX_DIR4, 32'he0);
        wb(1'b1, `GPIO_IDX_DAT4, 32'he0);
        osc_in_use <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(oe_w[2], 8'h20);
        rd_chk(`GPIO_IDX_DAT4, 32'h20);
        osc_in_use <= 1'b0;
        analog_pin <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(lvl_w[2][2], 1'b1);
        rd_chk(`GPIO_IDX_DAT4, 32'he4);
        adc_in_use <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(lvl_w[2][2], 1'b0);
        rd_chk(`GPIO_IDX_DAT4, 32'he0);
        wb(1'b1, 8'h10, 32'hff);
        rd_chk(8'h10, 32'h0);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd_chk(`GPIO_IDX_DIR4, 32'h0);
        summarize();
    end
endmodule // tb_general_purpose_io_port
`default_nettype wire
